// [sched_timer_regs.vh]
// Register offsets, fields, reset values and timing counts of the timer
`ifndef SCHED_TIMER_REGS_VH
`define SCHED_TIMER_REGS_VH
// ==========================================================
// Register byte offsets
`define REG_COMMAND 8'h00
`define REG_RESULT 8'h04
`define REG_STATUS 8'h08
`define REG_MASK 8'h0C
`define REG_STATE 8'h10
`define REG_CALL 8'h14
// ==========================================================
// Command word fields
`define CMD_DATA_LSB 0
`define CMD_DATA_MSB 15
`define CMD_FUNC_LSB 16
`define CMD_FUNC_MSB 27
`define CMD_DESIG_LSB 28
`define CMD_DESIG_MSB 31
// ==========================================================
// Function codes, designator, routine number (BCD)
`define FUNC_INTERVAL 12'h000
`define FUNC_FIRST 12'h001
`define FUNC_READ 12'h002
`define DESIG_TIMER 4'h4
`define ROUTINE_TIMER 8'h99
// ==========================================================
// Status bits
`define ST_EXPIRY 0
`define ST_CALL 1
`define ST_ERROR 2
// ==========================================================
// Reset values
`define RST_TIME 16'h0000
`define RST_MASK 3'h0
// ==========================================================
// Time base
`define TICK_NS 10000000
`define CLK_NS 100
`endif

// [tick_gen.v]
// Free-running 10 ms time base pulse generator
`timescale 1ns/1ns
module tick_gen #(
  parameter DIV = 100000
)
(
  input wire clk,
  input wire rst,
  output reg tick
);
  reg [31:0] cnt_q;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 32'h0000_0000;
      tick <= 1'b0;
    end
    else if (cnt_q == DIV - 1)
    begin
      cnt_q <= 32'h0000_0000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 32'h0000_0001;
      tick <= 1'b0;
    end
  end
endmodule

// [bcd_down.v]
// Four-digit BCD decrement by one, plus validity check
`timescale 1ns/1ns
module bcd_down (
  input wire [15:0] value,
  output reg [15:0] less_one,
  output reg is_bcd
);
  integer i;
  reg borrow;
  reg [3:0] dig;
  always @*
  begin
    borrow = 1'b1;
    is_bcd = 1'b1;
    less_one = 16'h0000;
    dig = 4'h0;
    for (i = 0; i < 4; i = i + 1)
    begin
      dig = value[i*4 +: 4];
      if (dig > 4'h9)
        is_bcd = 1'b0;
      if (borrow)
      begin
        if (dig == 4'h0)
          less_one[i*4 +: 4] = 4'h9;
        else
        begin
          less_one[i*4 +: 4] = dig - 4'h1;
          borrow = 1'b0;
        end
      end
      else
        less_one[i*4 +: 4] = dig;
    end
  end
endmodule

// [sched_timer.v]
// Scheduled interrupt timer with a classic Wishbone register slave
// Function
// [RULE1] Function code 000 loads interval, 001 first delay, 002 reads.
// [RULE2] Software always gives interrupt designator four.
// [RULE3] Interval 00.01 to 99.99 s in BCD hundredths, changeable anytime.
// [RULE4] Interval zero cancels further timer interrupts.
// [RULE5] New interval waits until after the next expiry.
// [RULE6] First delay restarts countdown now, then repeat interval follows.
// [RULE7] First delay 00.01 to 99.99 s; zero suppresses the interrupt.
// [RULE8] Every first-delay reload restarts the countdown.
// [RULE9] Function 002 copies the effective interval to the result word.
// [RULE10] Each expiry starts routine 99, independent of program cycle.
// [RULE11] No interrupts after power-up until times are loaded.
// [RULE12] Software should load both interval and first delay.
// [RULE13] Bad function, data or designator sets error and skips.
// [RULE14] Immediate data only for 000 and 001; 002 names a word. Code ignores 002 data and always puts the result in REG_RESULT.
// [RULE15] After the routine, the program resumes where it stopped.
// [RULE16] No timer commands during step-sequenced sections.
// [RULE17] Routine 99 may also be called directly by the program.
// [RULE18] Count down per 10 ms tick, reload interval on expiry.
// [RULE19] Reset clears interval and first delay, timer idle.
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "sched_timer_regs.vh"
module sched_timer #(
  parameter TICK_DIV = `TICK_NS / `CLK_NS
)
(
  // Clock and reset
  input wire REF_CLK,
  input wire SYS_RST,
  // Wishbone slave
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  // Interrupt and routine dispatch
  output reg IRQ,
  output reg ROUTINE_START,
  output reg [7:0] ROUTINE_NUM,
  output reg ERROR_FLAG
);
  // ==========================================================
  // State
  reg [15:0] interval_q;
  reg [15:0] pending_q;
  reg pending_valid_q;
  reg [15:0] count_q;
  reg running_q;
  reg [31:0] result_q;
  reg [2:0] status_q;
  reg [2:0] mask_q;
  wire tick;
  wire [15:0] count_less;
  wire count_ok;
  wire [15:0] cmd_less;
  wire cmd_bcd;

  // ==========================================================
  // Time base and arithmetic
  tick_gen #(.DIV(TICK_DIV)) u_tick (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .tick(tick)
  );

  bcd_down u_count (
    .value(count_q),
    .less_one(count_less),
    .is_bcd(count_ok)
  );

  wire [31:0] wdat = WB_DAT_I;
  wire [15:0] cmd_data = wdat[`CMD_DATA_MSB:`CMD_DATA_LSB];
  wire [11:0] cmd_func = wdat[`CMD_FUNC_MSB:`CMD_FUNC_LSB];
  wire [3:0] cmd_desig = wdat[`CMD_DESIG_MSB:`CMD_DESIG_LSB];

  bcd_down u_cmd (
    .value(cmd_data),
    .less_one(cmd_less),
    .is_bcd(cmd_bcd)
  );

  // ==========================================================
  // Bus decode
  wire req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wr = req & WB_WE_I & (WB_SEL_I == 4'hF);
  wire wr_cmd = wr & (WB_ADR_I == `REG_COMMAND);
  wire wr_status = wr & (WB_ADR_I == `REG_STATUS);
  wire wr_mask = wr & (WB_ADR_I == `REG_MASK);
  wire wr_call = wr & (WB_ADR_I == `REG_CALL) & wdat[0];

  wire func_ok = (cmd_func == `FUNC_INTERVAL) | // RULE1
    (cmd_func == `FUNC_FIRST) | (cmd_func == `FUNC_READ);
  wire cmd_bad = (cmd_desig != `DESIG_TIMER) | ~func_ok | // RULE13
    (~cmd_bcd & (cmd_func != `FUNC_READ));
  wire do_interval = wr_cmd & ~cmd_bad & (cmd_func == `FUNC_INTERVAL);
  wire do_first = wr_cmd & ~cmd_bad & (cmd_func == `FUNC_FIRST);
  wire do_read = wr_cmd & ~cmd_bad & (cmd_func == `FUNC_READ);

  // Expiry when the last hundredth elapses
  wire expire = running_q & tick & (count_q == 16'h0001) & count_ok; // RULE18
  wire [15:0] next_interval = pending_valid_q ? pending_q : interval_q;

  // ==========================================================
  // Interval and countdown
  always @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      interval_q <= `RST_TIME; // RULE19
      pending_q <= `RST_TIME;
      pending_valid_q <= 1'b0;
      count_q <= `RST_TIME;
      running_q <= 1'b0; // RULE11
    end
    else
    begin
      if (expire)
      begin
        interval_q <= next_interval; // RULE5
        pending_valid_q <= 1'b0;
        count_q <= next_interval; // RULE18
        running_q <= (next_interval != 16'h0000); // RULE4
      end
      else if (running_q & tick)
        count_q <= count_less;
      if (do_interval)
      begin
        if (running_q & ~expire)
        begin
          pending_q <= cmd_data; // RULE5
          pending_valid_q <= 1'b1;
        end
        else
        begin
          interval_q <= cmd_data; // RULE3
          pending_valid_q <= 1'b0;
        end
        if (cmd_data == 16'h0000)
          running_q <= 1'b0; // RULE4
      end
      if (do_first)
      begin
        count_q <= cmd_data; // RULE6 RULE8
        running_q <= (cmd_data != 16'h0000); // RULE7
      end
    end
  end

  // ==========================================================
  // Status, mask, result, outputs
  wire [2:0] events = {wr_cmd & cmd_bad, wr_call, expire};
  wire [2:0] clr = wr_status ? wdat[2:0] : 3'h0;
  wire [2:0] status_d = (status_q & ~clr) | events;

  always @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      status_q <= 3'h0;
      mask_q <= `RST_MASK;
      result_q <= 32'h0000_0000;
      IRQ <= 1'b0;
      ROUTINE_START <= 1'b0;
      ROUTINE_NUM <= 8'h00;
      ERROR_FLAG <= 1'b0;
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end
    else
    begin
      status_q <= status_d; // RULE13
      if (wr_mask)
        mask_q <= wdat[2:0];
      if (do_read)
        result_q <= {16'h0000, interval_q}; // RULE9
      if (wr_cmd)
        ERROR_FLAG <= cmd_bad; // RULE13
      IRQ <= |(status_d & mask_q);
      ROUTINE_START <= expire | wr_call; // RULE10 RULE15 RULE17
      if (expire | wr_call)
        ROUTINE_NUM <= `ROUTINE_TIMER;
      WB_ACK_O <= req;
      WB_DAT_O <= 32'h0000_0000;
      if (req & ~WB_WE_I)
      begin
        case (WB_ADR_I)
          `REG_RESULT: WB_DAT_O <= result_q;
          `REG_STATUS: WB_DAT_O <= {29'h0, status_q};
          `REG_MASK: WB_DAT_O <= {29'h0, mask_q};
          `REG_STATE: WB_DAT_O <= {count_q, interval_q};
          default: WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// [sched_timer_monitor.sv]
// Bus and dispatch checker for the scheduled timer
`timescale 1ns/1ns
module sched_timer_monitor (
  // Clock and bus
  input wire REF_CLK,
  input wire SYS_RST,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire WB_ACK_O,
  // Events
  input wire IRQ,
  input wire ROUTINE_START,
  input wire [7:0] ROUTINE_NUM,
  input wire ERROR_FLAG
);
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);
  wire ev = ROUTINE_START || WB_ACK_O;
  sequence taken;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  chk_ack_follows: assert property (taken |=> WB_ACK_O)
    else $error("ack late");
  chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack long");
  chk_ack_idle: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
    else $error("ack stray");
  chk_reset_quiet: assert property ($fell(SYS_RST) |->
    !IRQ && !ROUTINE_START && !ERROR_FLAG) else $error("busy at reset");
  chk_err_cause: assert property ($changed(ERROR_FLAG) |->
    $past(WB_WE_I && WB_CYC_I)) else $error("error flag stray");
  chk_irq_cause: assert property ($rose(IRQ) |->
    ev || $past(ev) || $past(ev, 2)) else $error("irq stray");
  chk_start_pulse: assert property (ROUTINE_START |=> !ROUTINE_START)
    else $error("start long");
  chk_routine_num: assert property (ROUTINE_START |=>
    ROUTINE_NUM == 8'h99) else $error("routine number");
endmodule
bind sched_timer sched_timer_monitor sched_timer_monitor_inst (.*);

// [sched_timer_tb_top.sv]
// Self-checking bench for the scheduled timer
`timescale 1ns/1ns
module sched_timer_tb_top;
  reg REF_CLK = 0;
  reg SYS_RST = 1;
  reg WB_CYC_I = 0;
  reg WB_STB_I = 0;
  reg WB_WE_I = 0;
  reg [7:0] WB_ADR_I = 0;
  reg [3:0] WB_SEL_I = 4'hF;
  reg [31:0] WB_DAT_I = 0;
  wire [31:0] WB_DAT_O;
  wire WB_ACK_O, IRQ, ROUTINE_START, ERROR_FLAG;
  wire [7:0] ROUTINE_NUM;
  integer miscompares = 0;
  integer checks_done = 0;
  integer starts = 0;
  integer cyc = 0;
  integer seed = 32'h384c;
  integer i, n;
  reg [31:0] exp_q[$];
  reg [31:0] r;
  sched_timer #(.TICK_DIV(10)) sched_timer_inst (.*);
  always #50 REF_CLK = ~REF_CLK;
  // ==========
  // Tasks
  task chk(input [31:0] got, input [31:0] want);
  begin
    checks_done = checks_done + 1;
    if (got !== want)
    begin
      miscompares = miscompares + 1;
      $display("MISMATCH %0t got %h exp %h", $time, got, want);
    end
  end
  endtask
  task final_report;
  begin
    if (miscompares == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  task w(input integer c);
    repeat (c) @(posedge REF_CLK);
  endtask
  task wb(input we, input [7:0] a, input [31:0] d);
  begin
    WB_CYC_I <= 1;
    WB_STB_I <= 1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    @(posedge REF_CLK);
    while (WB_ACK_O !== 1'b1) @(posedge REF_CLK);
    WB_CYC_I <= 0;
    WB_STB_I <= 0;
    @(posedge REF_CLK);
  end
  endtask
  task rd(input [7:0] a, input [31:0] e);
  begin
    exp_q.push_back(e);
    wb(0, a, 0);
  end
  endtask
  task cmd(input [11:0] f, input [15:0] d);
    wb(1, 8'h00, {4'h4, f, d});
  endtask
  // ==========
  // Result watcher and timeout
  always @(posedge REF_CLK)
  begin
    cyc <= cyc + 1;
    if (ROUTINE_START === 1'b1) starts <= starts + 1;
    if (WB_ACK_O === 1'b1 && !WB_WE_I) chk(WB_DAT_O, exp_q.pop_front());
    if (cyc == 4000)
    begin
      miscompares = miscompares + 1;
      final_report;
    end
  end
  // ==========
  // Scenarios
  initial
  begin
    w(4);
    SYS_RST <= 0;
    w(1);
    rd(8'h10, 0);
    w(300);
    chk(starts, 0);
    cmd(12'h000, 16'h0008);
    cmd(12'h002, 16'h0000);
    rd(8'h04, 32'h0000_0008);
    rd(8'h10, 32'h0000_0008);
    cmd(12'h001, 16'h0003);
    w(15);
    chk(starts, 0);
    w(25);
    chk(starts, 1);
    w(55);
    chk(starts, 1);
    w(25);
    chk(starts, 2);
    cmd(12'h000, 16'h0002);
    w(50);
    chk(starts, 2);
    w(24);
    chk(starts, 3);
    w(20);
    chk(starts, 4);
    cmd(12'h001, 16'h0003);
    n = starts;
    for (i = 0; i < 8; i = i + 1)
    begin
      cmd(12'h001, 16'h0003);
      w(15);
    end
    chk(starts, n);
    cmd(12'h000, 16'h0000);
    n = starts;
    w(200);
    chk(starts, n);
    cmd(12'h000, 16'h0002);
    cmd(12'h001, 16'h0000);
    w(100);
    chk(starts, n);
    wb(1, 8'h08, 32'h0000_0007);
    wb(1, 8'h0C, 32'h0000_0007);
    rd(8'h0C, 32'h0000_0007);
    chk(IRQ, 0);
    wb(1, 8'h14, 32'h0000_0001);
    w(3);
    chk({IRQ, ROUTINE_NUM}, 32'h0000_0199);
    rd(8'h08, 32'h0000_0002);
    wb(1, 8'h0C, 0);
    w(3);
    chk(IRQ, 0);
    wb(1, 8'h08, 32'h0000_0007);
    for (i = 0; i < 8; i = i + 1)
    begin
      r = $random(seed);
      if (r[31:28] == 4'h4) r[31:28] = 4'h5;
      if (i[0]) r[31:16] = {8'h40, r[23:16] | 8'h10};
      wb(1, 8'h00, r);
      chk(ERROR_FLAG, 1);
    end
    wb(1, 8'h00, 32'h4001_00A0);
    chk(ERROR_FLAG, 1);
    rd(8'h08, 32'h0000_0004);
    cmd(12'h000, 16'h0000);
    chk(ERROR_FLAG, 0);
    wb(1, 8'h08, 32'h0000_0004);
    rd(8'h08, 0);
    rd(8'h20, 0);
    final_report;
  end
endmodule
